//--- logic/stc_regs.svh
// Register offsets, field positions and reset values of the 16-bit timer
`ifndef STC_REGS_SVH
`define STC_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (8-bit I/O space)
// ----------------------------------------------------------------
`define STC_ADDR_MASK       8'h6f
`define STC_ADDR_FLAGS      8'h36
`define STC_ADDR_CONTROL    8'h81
`define STC_ADDR_COUNT_LO   8'h84
`define STC_ADDR_COUNT_HI   8'h85
`define STC_ADDR_CMP_LO     8'h88
`define STC_ADDR_CMP_HI     8'h89

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define STC_CTL_CS_LSB      0
`define STC_CTL_CS_MSB      2
`define STC_CTL_CLR_BIT     3
`define STC_FLG_OVF_BIT     0
`define STC_FLG_CMP_BIT     1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define STC_RST_BYTE        8'h00
`define STC_RST_WORD        16'h0000
`define STC_COUNT_MAX       16'hffff

`endif

//--- logic/stc_pkg.sv
// Types shared by the 16-bit timer
package stc_pkg;

    // ----------------------------------------------------------------
    // Clock select codes
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        STC_CS_STOP  = 3'h0,
        STC_CS_DIV1  = 3'h1,
        STC_CS_DIV8  = 3'h2,
        STC_CS_DIV32 = 3'h3,
        STC_CS_DIV64 = 3'h4,
        STC_CS_DIV128 = 3'h5,
        STC_CS_DIV256 = 3'h6,
        STC_CS_DIV1024 = 3'h7
    } stc_cs_t;

    // ----------------------------------------------------------------
    // Prescaler tap pulses, one I/O clock wide each
    // ----------------------------------------------------------------
    typedef struct packed {
        logic div1024;
        logic div256;
        logic div128;
        logic div64;
        logic div32;
        logic div8;
    } stc_taps_t;

    // ----------------------------------------------------------------
    // Register access strobe bundle
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic       rd;
        logic       wr;
        logic [7:0] wdata;
    } stc_bus_t;

endpackage : stc_pkg

//--- logic/stc_timer.sv
// 16-bit timer with one compare channel and shared high-byte holding register
`timescale 1ns/10ps
`include "stc_regs.svh"

module stc_timer
(
    // Clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    // Register access
    input  wire stc_pkg::stc_bus_t i_bus,
    output logic [7:0]             o_rdata,
    // Prescaler taps and interrupt system
    input  wire stc_pkg::stc_taps_t i_taps,
    input  wire logic              i_global_irq_en,
    input  wire logic              i_cmp_vector_ack,
    input  wire logic              i_ovf_vector_ack,
    // Interrupt requests
    output logic                   o_cmp_irq,
    output logic                   o_ovf_irq
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [7:0]  hold_r;
    logic [15:0] count_r;
    logic [15:0] compare_r;
    logic [3:0]  control_r;
    logic [1:0]  mask_r;
    logic        cmp_flag_r;
    logic        ovf_flag_r;
    logic        block_r;
    logic [7:0]  rdata_r;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire logic wr_count_lo = i_bus.wr && (i_bus.addr == `STC_ADDR_COUNT_LO);
    wire logic rd_count_lo = i_bus.rd && (i_bus.addr == `STC_ADDR_COUNT_LO);
    wire logic wr_cmp_lo   = i_bus.wr && (i_bus.addr == `STC_ADDR_CMP_LO);
    // Both upper-byte locations write the single holding register
    wire logic wr_hold     = i_bus.wr && ((i_bus.addr == `STC_ADDR_COUNT_HI) ||
                                          (i_bus.addr == `STC_ADDR_CMP_HI));
    wire logic wr_ctl      = i_bus.wr && (i_bus.addr == `STC_ADDR_CONTROL);
    wire logic wr_mask     = i_bus.wr && (i_bus.addr == `STC_ADDR_MASK);
    wire logic wr_flags    = i_bus.wr && (i_bus.addr == `STC_ADDR_FLAGS);

    // ----------------------------------------------------------------
    // Count source and counter datapath
    // ----------------------------------------------------------------
    wire stc_pkg::stc_cs_t cs = stc_pkg::stc_cs_t'(control_r[`STC_CTL_CS_MSB:`STC_CTL_CS_LSB]);
    logic tick;

    always_comb
    begin
        unique case (cs)
            stc_pkg::STC_CS_STOP:    tick = 1'b0;
            stc_pkg::STC_CS_DIV1:    tick = 1'b1;
            stc_pkg::STC_CS_DIV8:    tick = i_taps.div8;
            stc_pkg::STC_CS_DIV32:   tick = i_taps.div32;
            stc_pkg::STC_CS_DIV64:   tick = i_taps.div64;
            stc_pkg::STC_CS_DIV128:  tick = i_taps.div128;
            stc_pkg::STC_CS_DIV256:  tick = i_taps.div256;
            stc_pkg::STC_CS_DIV1024: tick = i_taps.div1024;
        endcase
    end

    wire logic        match     = (count_r == compare_r);
    // A count write blocks the match seen at the next tick, so the flag stays quiet
    wire logic        cmp_event = tick && match && !block_r;
    wire logic        do_clear  = cmp_event && control_r[`STC_CTL_CLR_BIT];
    // A count write in the same cycle replaces the wrap, so no overflow either
    wire logic        ovf_event = tick && !do_clear && !wr_count_lo &&
                                  (count_r == `STC_COUNT_MAX);
    wire logic [15:0] count_inc = count_r + 16'h0001;
    wire logic [15:0] count_nxt = wr_count_lo ? {hold_r, i_bus.wdata} :
                                  do_clear    ? `STC_RST_WORD :
                                  tick        ? count_inc : count_r;

    // Block stays armed until a tick consumes it, even while stopped
    wire logic block_nxt = wr_count_lo ? 1'b1 : (tick ? 1'b0 : block_r);

    // Hardware set wins over software or vector clear
    wire logic cmp_clr      = i_cmp_vector_ack || (wr_flags && i_bus.wdata[`STC_FLG_CMP_BIT]);
    wire logic ovf_clr      = i_ovf_vector_ack || (wr_flags && i_bus.wdata[`STC_FLG_OVF_BIT]);
    wire logic cmp_flag_nxt = cmp_event || (cmp_flag_r && !cmp_clr);
    wire logic ovf_flag_nxt = ovf_event || (ovf_flag_r && !ovf_clr);

    // Holding register: written upper byte, or snapshot on low count read
    wire logic [7:0] hold_nxt = wr_hold     ? i_bus.wdata :
                                rd_count_lo ? count_r[15:8] : hold_r;

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    logic [7:0] rdata_nxt;

    always_comb
    begin
        unique case (i_bus.addr)
            `STC_ADDR_COUNT_LO: rdata_nxt = count_r[7:0];
            `STC_ADDR_COUNT_HI: rdata_nxt = hold_r;
            `STC_ADDR_CMP_LO:   rdata_nxt = compare_r[7:0];
            `STC_ADDR_CMP_HI:   rdata_nxt = compare_r[15:8];
            `STC_ADDR_CONTROL:  rdata_nxt = {4'h0, control_r};
            `STC_ADDR_MASK:     rdata_nxt = {6'h00, mask_r};
            `STC_ADDR_FLAGS:    rdata_nxt = {6'h00, cmp_flag_r, ovf_flag_r};
            default:            rdata_nxt = `STC_RST_BYTE;
        endcase
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            hold_r     <= `STC_RST_BYTE;
            count_r    <= `STC_RST_WORD;
            compare_r  <= `STC_RST_WORD;
            control_r  <= 4'h0;
            mask_r     <= 2'h0;
            cmp_flag_r <= 1'b0;
            ovf_flag_r <= 1'b0;
            block_r    <= 1'b0;
            rdata_r    <= `STC_RST_BYTE;
        end
        else
        begin
            hold_r     <= hold_nxt;
            count_r    <= count_nxt;
            block_r    <= block_nxt;
            cmp_flag_r <= cmp_flag_nxt;
            ovf_flag_r <= ovf_flag_nxt;
            if (i_bus.rd)
                rdata_r <= rdata_nxt;
            if (wr_cmp_lo)
                compare_r <= {hold_r, i_bus.wdata};
            if (wr_ctl)
                control_r <= i_bus.wdata[3:0];
            if (wr_mask)
                mask_r <= i_bus.wdata[1:0];
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_rdata   = rdata_r;
    assign o_cmp_irq = mask_r[`STC_FLG_CMP_BIT] && i_global_irq_en && cmp_flag_r;
    assign o_ovf_irq = mask_r[`STC_FLG_OVF_BIT] && i_global_irq_en && ovf_flag_r;

endmodule : stc_timer

//--- bench/stc_timer_properties.sv
// Port checker for the 16-bit timer
`timescale 1ns/10ps
`include "stc_regs.svh"
module stc_timer_properties
(
    // Watched ports
    input wire logic                i_clk,
    input wire logic                i_rst_n,
    input wire stc_pkg::stc_bus_t   i_bus,
    input wire logic [7:0]          o_rdata,
    input wire stc_pkg::stc_taps_t  i_taps,
    input wire logic                i_global_irq_en,
    input wire logic                i_cmp_vector_ack,
    input wire logic                i_ovf_vector_ack,
    input wire logic                o_cmp_irq,
    input wire logic                o_ovf_irq
);
    // ----
    // Decode and properties
    // ----
    wire rd_msk = i_bus.rd && i_bus.addr == `STC_ADDR_MASK;
    wire wr_msk = i_bus.wr && i_bus.addr == `STC_ADDR_MASK;
    wire rd_flg = i_bus.rd && i_bus.addr == `STC_ADDR_FLAGS;
    wire rd_ctl = i_bus.rd && i_bus.addr == `STC_ADDR_CONTROL;
    wire rd_map = i_bus.addr inside {8'h6f, 8'h36, 8'h81, 8'h84, 8'h85, 8'h88, 8'h89};
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    property p_mask_rd;
        logic [7:0] v;
        (wr_msk, v = i_bus.wdata) ##1 rd_msk |=> o_rdata == {6'h00, v[1:0]};
    endproperty
    // Compare high read returns the high byte written before the compare low write
    property p_cmp_rd;
        logic [7:0] v;
        (i_bus.wr && i_bus.addr == `STC_ADDR_CMP_HI, v = i_bus.wdata)
            ##1 (i_bus.wr && i_bus.addr == `STC_ADDR_CMP_LO)
            ##1 (i_bus.rd && i_bus.addr == `STC_ADDR_CMP_HI) |=> o_rdata == v;
    endproperty
    AST_CMP_GLB: assert property (o_cmp_irq |-> i_global_irq_en)
        else $error("compare irq ungated");
    AST_OVF_GLB: assert property (o_ovf_irq |-> i_global_irq_en)
        else $error("overflow irq ungated");
    AST_MSK_OFF: assert property (wr_msk && i_bus.wdata[1:0] == 2'h0 |=> !o_cmp_irq && !o_ovf_irq)
        else $error("irq unmasked");
    AST_MSK_RD: assert property (p_mask_rd)
        else $error("mask readback wrong");
    AST_FLG_RSV: assert property (rd_flg |=> o_rdata[7:2] == 6'h00)
        else $error("flag reserved bits set");
    AST_CTL_RSV: assert property (rd_ctl |=> o_rdata[7:4] == 4'h0)
        else $error("control reserved bits set");
    AST_UNMAP: assert property (i_bus.rd && !rd_map |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_RD_HOLD: assert property (!i_bus.rd |=> $stable(o_rdata))
        else $error("read data moved");
    AST_CMP_RD: assert property (p_cmp_rd)
        else $error("compare high read wrong");
    COV_CMP: cover property (o_cmp_irq);
    COV_OVF: cover property (o_ovf_irq);
    COV_CRD: cover property (p_cmp_rd);
endmodule : stc_timer_properties

bind stc_timer stc_timer_properties u_props (.i_clk, .i_rst_n, .i_bus, .o_rdata, .i_taps, .i_global_irq_en,
    .i_cmp_vector_ack, .i_ovf_vector_ack, .o_cmp_irq, .o_ovf_irq);

//--- bench/stc_timer_tb.sv
// Self-checking bench for the 16-bit timer
`timescale 1ns/10ps
module stc_timer_tb;
    // ----
    // Signals, tasks and sequence
    // ----
    logic               i_clk, i_rst_n, i_global_irq_en, i_cmp_vector_ack, i_ovf_vector_ack;
    logic               o_cmp_irq, o_ovf_irq, rd_q;
    stc_pkg::stc_bus_t  i_bus;
    stc_pkg::stc_taps_t i_taps;
    logic [7:0]         o_rdata;
    logic [7:0]         exp_q [$];
    logic [15:0]        cmp;
    logic [7:0]         adr [8] = '{8'h6f, 8'h36, 8'h81, 8'h84, 8'h85, 8'h88, 8'h89, 8'h40};
    int                 bad_count, check_count;
    stc_timer dut (.i_clk, .i_rst_n, .i_bus, .o_rdata, .i_taps, .i_global_irq_en,
        .i_cmp_vector_ack, .i_ovf_vector_ack, .o_cmp_irq, .o_ovf_irq);
    task check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task print_verdict;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict
    // Read data is one cycle late, so the monitor pairs it through the queue
    task acc(input logic r, input logic [7:0] a, input logic [7:0] d);
        i_bus = '{a, r, !r, d};
        if (r)
            exp_q.push_back(d);
        @(negedge i_clk);
    endtask : acc
    task w16(input logic [7:0] a, input logic [15:0] v);
        acc(1'b0, a + 8'h01, v[15:8]);
        acc(1'b0, a, v[7:0]);
    endtask : w16
    task tick(input int k);
        i_bus = '0;
        i_taps = 6'h01 << k;
        @(negedge i_clk);
        i_taps = '0;
        @(negedge i_clk);
    endtask : tick
    always @(posedge i_clk) rd_q <= i_bus.rd;
    always @(negedge i_clk)
        if (rd_q === 1'b1)
            check(o_rdata, exp_q.pop_front());
    initial
    begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    initial
    begin
        #1000000 bad_count++;
        print_verdict();
    end
    initial
    begin
        // No handler shares the holding byte, so pairs need no masking
        {i_rst_n, i_global_irq_en, i_cmp_vector_ack, i_ovf_vector_ack, i_bus, i_taps} = '0;
        cmp = 16'($urandom(30));
        repeat (5) @(negedge i_clk);
        i_rst_n = 1'b1;
        foreach (adr[i]) acc(1'b1, adr[i], 8'h00);
        acc(1'b0, 8'h6f, 8'hff);
        acc(1'b1, 8'h6f, 8'h03);
        acc(1'b0, 8'h81, 8'hf8);
        acc(1'b1, 8'h81, 8'h08);
        $display("test reset and reserved done");
        w16(8'h84, 16'h01ff);
        acc(1'b1, 8'h84, 8'hff);
        acc(1'b1, 8'h85, 8'h01);
        w16(8'h88, cmp);
        acc(1'b1, 8'h89, cmp[15:8]);
        acc(1'b1, 8'h88, cmp[7:0]);
        acc(1'b0, 8'h84, 8'h22);
        acc(1'b1, 8'h84, 8'h22);
        acc(1'b1, 8'h85, cmp[15:8]);
        $display("test holding byte done");
        w16(8'h88, 16'h0005);
        w16(8'h84, 16'hfffe);
        // Wrong tap per code must not count
        for (int k = 0; k < 6; k++)
        begin
            acc(1'b0, 8'h81, 8'(k + 2));
            tick(k);
            tick((k + 1) % 6);
        end
        acc(1'b0, 8'h81, 8'h00);
        tick(0);
        acc(1'b1, 8'h84, 8'h04);
        acc(1'b1, 8'h36, 8'h01);
        acc(1'b0, 8'h6f, 8'h01);
        i_global_irq_en = 1'b1;
        i_bus = '0;
        @(negedge i_clk);
        check(o_ovf_irq, 1'b1);
        acc(1'b0, 8'h36, 8'h01);
        i_bus = '0;
        check(o_ovf_irq, 1'b0);
        $display("test counting done");
        w16(8'h84, 16'h0005);
        acc(1'b0, 8'h81, 8'h0a);
        tick(0);
        acc(1'b1, 8'h36, 8'h00);
        w16(8'h84, 16'h0004);
        tick(0);
        tick(0);
        acc(1'b0, 8'h36, 8'h00);
        acc(1'b1, 8'h36, 8'h02);
        acc(1'b1, 8'h84, 8'h00);
        acc(1'b0, 8'h6f, 8'h02);
        i_bus = '0;
        @(negedge i_clk);
        check(o_cmp_irq, 1'b1);
        i_cmp_vector_ack = 1'b1;
        @(negedge i_clk);
        check(o_cmp_irq, 1'b0);
        i_cmp_vector_ack = 1'b0;
        acc(1'b0, 8'h6f, 8'h00);
        acc(1'b1, 8'h85, 8'h00);
        i_bus = '0;
        @(negedge i_clk);
        $display("test compare done");
        print_verdict();
    end
endmodule : stc_timer_tb
